// ==== rtl/bha_core.sv ====
// Operation
// - Float address, enables, data, lock, definition, strobe; then raise grant.
// - Keep bus released while takeover request stays high.
// - Request low drops grant and redrives bus in same clock.
// - During reset the request is ignored and grant stays low.
// - Reset during hold wins; bus driven to idle levels.
// - Request is active-high level input synchronous to this clock.
// - While released only the grant is driven; all else floats.
// - One unmaskable interrupt rising edge during hold is remembered, served later.
// - No grant before current bus operation completes, any wait states.
// - 32-bit access becomes two locked 16-bit cycles, lock pin unasserted.
// - Unaligned access becomes 2 or 3 locked cycles; request deferred until end.
// - Grant delayed while lock-prefixed atomic sequence runs.
// - Reset drives idle bus levels listed for each output.
// - Cycle completes only on sampled transfer-done; ignored in first state.
`timescale 1ns/1ps
module bha_core (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic bus_reset,
  input wire logic takeover_req,
  input wire logic xfer_done_n,
  input wire logic nmi_pin,
  input wire logic op_valid,
  input wire logic [bha_pkg::ADDR_W-1:0] op_addr,
  input wire logic op_write,
  input wire logic op_data_cycle,
  input wire logic op_mem,
  input wire logic [1:0] op_pieces,
  input wire logic op_lock_seq,
  input wire logic [bha_pkg::DATA_W-1:0] op_wdata,
  input wire logic seq_active,
  input wire logic nmi_served,
  output logic op_ready,
  output logic op_done,
  output logic [bha_pkg::DATA_W-1:0] op_rdata,
  output logic nmi_pending,
  output logic bus_grant_ack,
  output logic address_strobe_n,
  output logic address_strobe_n_oe,
  output logic upper_byte_enable_n,
  output logic lower_byte_enable_n,
  output logic byte_enable_oe,
  output logic [bha_pkg::ADDR_W-1:0] address_lines,
  output logic address_lines_oe,
  output logic write_read,
  output logic data_control,
  output logic mem_io,
  output logic cycle_def_oe,
  output logic lock_n,
  output logic lock_n_oe,
  input wire logic [bha_pkg::DATA_W-1:0] data_lines_in,
  output logic [bha_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe
);
  import bha_pkg::*;

  bha_bus_e bus_st;
  bha_arb_e arb_st;
  logic [1:0] pieces_left;
  logic locked_seq;
  logic nmi_s;
  logic nmi_prev;
  logic in_reset;

  assign in_reset = bus_reset;

  bha_sync u_nmi_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .din(nmi_pin),
    .dout(nmi_s)
  );

  // Completion only counts past the first bus state
  wire cycle_end = (bus_st == BHA_T2) && !xfer_done_n;
  wire last_piece = (pieces_left == PIECES_ONE);
  wire op_end = cycle_end && last_piece;
  wire boundary = (bus_st == BHA_IDLE) || op_end;
  // Split pieces and atomic sequences keep the bus
  wire bus_busy = ((bus_st != BHA_IDLE) && !op_end) || locked_seq || seq_active;
  wire hold_ok = takeover_req && !in_reset && boundary && !bus_busy;
  wire released = (arb_st != BHA_OWN);
  wire start_ok = (bus_st == BHA_IDLE) && !released && !takeover_req && !in_reset;
  wire nmi_rise = nmi_s && !nmi_prev;

  assign op_ready = start_ok;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arb_st <= BHA_OWN;
    end else if (in_reset) begin
      arb_st <= BHA_OWN;
    end else begin
      unique case (arb_st)
        BHA_OWN: if (hold_ok) arb_st <= BHA_FLOAT;
        BHA_FLOAT: arb_st <= takeover_req ? BHA_HELD : BHA_OWN;
        BHA_HELD: if (!takeover_req) arb_st <= BHA_OWN;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_st <= BHA_IDLE;
      pieces_left <= 2'h0;
      locked_seq <= 1'b0;
      address_lines <= ADDR_IDLE;
      upper_byte_enable_n <= BE_N_IDLE;
      lower_byte_enable_n <= BE_N_IDLE;
      write_read <= WR_IDLE;
      data_control <= DC_IDLE;
      mem_io <= MIO_IDLE;
      address_strobe_n <= ADS_N_IDLE;
      lock_n <= LOCK_N_IDLE;
      data_lines_out <= '0;
      op_done <= 1'b0;
      op_rdata <= '0;
    end else if (in_reset) begin
      bus_st <= BHA_IDLE;
      pieces_left <= 2'h0;
      locked_seq <= 1'b0;
      address_lines <= ADDR_IDLE;
      upper_byte_enable_n <= BE_N_IDLE;
      lower_byte_enable_n <= BE_N_IDLE;
      write_read <= WR_IDLE;
      data_control <= DC_IDLE;
      mem_io <= MIO_IDLE;
      address_strobe_n <= ADS_N_IDLE;
      lock_n <= LOCK_N_IDLE;
      op_done <= 1'b0;
    end else begin
      op_done <= 1'b0;
      unique case (bus_st)
        BHA_IDLE: begin
          if (start_ok && op_valid) begin
            bus_st <= BHA_T1;
            pieces_left <= (op_pieces == 2'h0 || op_pieces > PIECES_MAX) ?
              PIECES_ONE : op_pieces;
            locked_seq <= op_lock_seq;
            address_lines <= op_addr;
            upper_byte_enable_n <= 1'b0;
            lower_byte_enable_n <= 1'b0;
            write_read <= op_write;
            data_control <= op_data_cycle;
            mem_io <= op_mem;
            address_strobe_n <= 1'b0;
            lock_n <= !op_lock_seq;
            data_lines_out <= op_wdata;
          end else begin
            locked_seq <= locked_seq && seq_active;
          end
        end
        BHA_T1: begin
          bus_st <= BHA_T2;
          address_strobe_n <= 1'b1;
        end
        BHA_T2: begin
          if (cycle_end) begin
            op_rdata <= data_lines_in;
            if (last_piece) begin
              bus_st <= BHA_IDLE;
              op_done <= 1'b1;
              lock_n <= LOCK_N_IDLE;
              locked_seq <= seq_active;
            end else begin
              // Next piece runs back to back, no hold window
              bus_st <= BHA_T1;
              pieces_left <= pieces_left - 2'h1;
              address_lines <= address_lines + 23'h1;
              address_strobe_n <= 1'b0;
            end
          end
        end
        default: bus_st <= BHA_IDLE;
      endcase
    end
  end

  // One remembered edge, set wins over the clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nmi_prev <= 1'b0;
      nmi_pending <= 1'b0;
    end else begin
      nmi_prev <= nmi_s;
      if (nmi_rise) begin
        nmi_pending <= 1'b1;
      end else if (nmi_served && !released) begin
        nmi_pending <= 1'b0;
      end
    end
  end

  // Grant only in the held state, a clock after the float
  assign bus_grant_ack = (arb_st == BHA_HELD) && !in_reset;
  wire drive = !released || in_reset;
  assign address_strobe_n_oe = drive;
  assign byte_enable_oe = drive;
  assign address_lines_oe = drive;
  assign cycle_def_oe = drive;
  assign lock_n_oe = drive;
  // Data floats in reset and on reads
  assign data_lines_oe = !released && !in_reset && (bus_st != BHA_IDLE) && write_read;

  property p_float_before_grant;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(bus_grant_ack) |-> !$past(address_lines_oe) && !address_lines_oe;
  endproperty
  a_float_before_grant: assert property (p_float_before_grant)
    else $error("grant raised before outputs floated");

  // Reset may still take the grant away in mid-hold
  property p_stay;
    @(posedge clk_sys) disable iff (!rstn)
    bus_grant_ack && takeover_req && !bus_reset |=> bus_grant_ack || bus_reset;
  endproperty
  a_stay: assert property (p_stay)
    else $error("grant dropped while request held");

  property p_release;
    @(posedge clk_sys) disable iff (!rstn)
    bus_grant_ack && !takeover_req && !bus_reset |=> !bus_grant_ack && address_lines_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("bus not retaken after request dropped");

  property p_reset_nogrant;
    @(posedge clk_sys) disable iff (!rstn)
    bus_reset |-> !bus_grant_ack;
  endproperty
  a_reset_nogrant: assert property (p_reset_nogrant)
    else $error("grant during reset");

  property p_reset_idle;
    @(posedge clk_sys) disable iff (!rstn)
    bus_reset ##1 bus_reset |-> address_lines_oe && address_strobe_n && lock_n
      && address_lines == ADDR_IDLE && !data_lines_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("idle levels not driven in reset");

  property p_reset_levels;
    @(posedge clk_sys) disable iff (!rstn)
    bus_reset ##1 bus_reset |-> upper_byte_enable_n == BE_N_IDLE && lower_byte_enable_n == BE_N_IDLE
      && write_read == WR_IDLE && data_control == DC_IDLE && mem_io == MIO_IDLE;
  endproperty
  a_reset_levels: assert property (p_reset_levels)
    else $error("cycle definition not idle in reset");

  property p_isolate;
    @(posedge clk_sys) disable iff (!rstn)
    bus_grant_ack |-> !address_strobe_n_oe && !byte_enable_oe && !cycle_def_oe
      && !lock_n_oe && !data_lines_oe;
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("pin driven during hold");

  property p_nmi_kept;
    @(posedge clk_sys) disable iff (!rstn)
    nmi_pending && bus_grant_ack |=> nmi_pending;
  endproperty
  a_nmi_kept: assert property (p_nmi_kept)
    else $error("remembered edge lost in hold");

  property p_no_mid_grant;
    @(posedge clk_sys) disable iff (!rstn)
    bus_st != BHA_IDLE |-> !bus_grant_ack;
  endproperty
  a_no_mid_grant: assert property (p_no_mid_grant)
    else $error("grant during bus cycle");

  property p_lock_pin;
    @(posedge clk_sys) disable iff (!rstn)
    !address_strobe_n && !locked_seq |-> lock_n;
  endproperty
  a_lock_pin: assert property (p_lock_pin)
    else $error("lock pin raised on split access");

  property p_split_keep;
    @(posedge clk_sys) disable iff (!rstn)
    cycle_end && !last_piece && !bus_reset |=> bus_st == BHA_T1 && !released;
  endproperty
  a_split_keep: assert property (p_split_keep)
    else $error("bus given up between split pieces");

  property p_seq_hold;
    @(posedge clk_sys) disable iff (!rstn)
    (seq_active || locked_seq) && !released |=> !released;
  endproperty
  a_seq_hold: assert property (p_seq_hold)
    else $error("bus released inside atomic sequence");

  // A reset in the first state abandons the cycle
  property p_done_first;
    @(posedge clk_sys) disable iff (!rstn)
    bus_st == BHA_T1 && !bus_reset |=> bus_st == BHA_T2;
  endproperty
  a_done_first: assert property (p_done_first)
    else $error("transfer-done honoured in first state");

  property p_grant_after_float;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(bus_grant_ack) |-> $past(arb_st) == BHA_FLOAT;
  endproperty
  a_grant_after_float: assert property (p_grant_after_float)
    else $error("grant raised without a float clock");

  c_grant: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(bus_grant_ack));
  c_split: cover property (@(posedge clk_sys) disable iff (!rstn)
    cycle_end && !last_piece);
  c_nmi_hold: cover property (@(posedge clk_sys) disable iff (!rstn)
    nmi_rise && bus_grant_ack);
  c_reset_hold: cover property (@(posedge clk_sys) disable iff (!rstn)
    bus_reset && takeover_req);
endmodule

// ==== rtl/bha_pkg.sv ====
package bha_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  // Idle bus levels driven while reset is active
  localparam logic ADS_N_IDLE = 1'h1;
  localparam logic BE_N_IDLE = 1'h0;
  localparam logic [ADDR_W-1:0] ADDR_IDLE = 23'h7FFFFF;
  localparam logic WR_IDLE = 1'h0;
  localparam logic DC_IDLE = 1'h1;
  localparam logic MIO_IDLE = 1'h0;
  localparam logic LOCK_N_IDLE = 1'h1;
  // Piece counts of split transfers
  localparam logic [1:0] PIECES_ONE = 2'h1;
  localparam logic [1:0] PIECES_MAX = 2'h3;
  // Bus cycle states
  typedef enum logic [1:0] {BHA_IDLE, BHA_T1, BHA_T2} bha_bus_e;
  // Arbitration states
  typedef enum logic [1:0] {BHA_OWN, BHA_FLOAT, BHA_HELD} bha_arb_e;
endpackage

// ==== rtl/bha_sync.sv ====
`timescale 1ns/1ps
module bha_sync (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  // Stage one feeds stage two only; a change counts when two and three agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

// ==== dv/bha_master_model.sv ====
`timescale 1ns/1ps
module bha_master_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  input wire logic [7:0] hold_len,
  input wire logic bus_grant_ack,
  output logic takeover_req
);
  logic [7:0] cnt;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      takeover_req <= 1'h0;
      cnt <= 8'h00;
    end else if (start && !takeover_req) begin
      takeover_req <= 1'h1;
      cnt <= hold_len;
    end else if (takeover_req && bus_grant_ack) begin
      // Request stays up until hold_len+1 granted clocks have passed, then drops
      if (cnt == 8'h00) begin
        takeover_req <= 1'h0;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// ==== dv/bus_hold_arbitration_test.sv ====
`timescale 1ns/1ps
module bus_hold_arbitration_test;
  import bha_pkg::*;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic bus_reset = 1'h0, start = 1'h0, xfer_done_n = 1'h1, nmi_pin = 1'h0;
  logic op_valid = 1'h0, op_write = 1'h0, seq_active = 1'h0, nmi_served = 1'h0;
  logic lock_seq = 1'h0;
  logic [1:0] op_pieces = 2'h1;
  logic [7:0] hold_len = 8'h04;
  logic takeover_req, op_ready, op_done, nmi_pending, gnt, s_n, s_oe, ub, lb, be_oe;
  logic a_oe, wr, dc, mio, cd_oe, lk, lk_oe, d_oe;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] rdata, dout;
  int num_errors = 0, checks_done = 0, cyc = 0;
  wire [4:0] oe_all = {s_oe, be_oe, a_oe, cd_oe, lk_oe};
  wire [30:0] idle = {ADS_N_IDLE, BE_N_IDLE, BE_N_IDLE, ADDR_IDLE, WR_IDLE, DC_IDLE,
    MIO_IDLE, LOCK_N_IDLE, 1'h0};
  wire [30:0] pins = {s_n, ub, lb, addr, wr, dc, mio, lk, gnt};
  always #2 clk_sys = ~clk_sys;

  bha_master_model master (.clk_sys(clk_sys), .rstn(rstn), .start(start),
    .hold_len(hold_len), .bus_grant_ack(gnt), .takeover_req(takeover_req));
  bha_core dut (.clk_sys(clk_sys), .rstn(rstn), .bus_reset(bus_reset),
    .takeover_req(takeover_req), .xfer_done_n(xfer_done_n), .nmi_pin(nmi_pin),
    .op_valid(op_valid), .op_addr(23'h000100), .op_write(op_write), .op_data_cycle(1'h1),
    .op_mem(1'h1), .op_pieces(op_pieces), .op_lock_seq(lock_seq), .op_wdata(16'h5AC3),
    .seq_active(seq_active), .nmi_served(nmi_served), .op_ready(op_ready),
    .op_done(op_done), .op_rdata(rdata), .nmi_pending(nmi_pending), .bus_grant_ack(gnt),
    .address_strobe_n(s_n), .address_strobe_n_oe(s_oe), .upper_byte_enable_n(ub),
    .lower_byte_enable_n(lb), .byte_enable_oe(be_oe), .address_lines(addr),
    .address_lines_oe(a_oe), .write_read(wr), .data_control(dc), .mem_io(mio),
    .cycle_def_oe(cd_oe), .lock_n(lk), .lock_n_oe(lk_oe), .data_lines_in(16'hA55A),
    .data_lines_out(dout), .data_lines_oe(d_oe));

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_sig(ref logic s, input logic v, input string n);
    for (int i = 0; i < 80 && s !== v; i++) tick(1);
    chk(n, v, s);
  endtask
  task automatic pulse_start();
    start = 1'h1;
    tick(1);
    start = 1'h0;
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Runs one grant and watches every sample of it
  task automatic t_hold();
    int n;
    n = 0;
    pulse_start();
    wait_sig(a_oe, 1'h0, "float");
    chk("gnt early", 0, gnt);
    tick(1);
    while (gnt === 1'h1 && n < 80) begin
      chk("oe held", 0, {oe_all, d_oe});
      n++;
      tick(1);
    end
    chk("gnt len", 1, n >= hold_len + 1);
    chk("redrive", 5'h1F, oe_all);
  endtask
  task automatic t_split();
    int n;
    n = 0;
    op_pieces = 2'h3;
    op_write = 1'h1;
    op_valid = 1'h1;
    wait_sig(op_ready, 1'h1, "ready");
    tick(1);
    op_valid = 1'h0;
    pulse_start();
    tick(8);
    // Transfer-done held off: the first piece stalls in wait states
    chk("gnt in wait", 0, {gnt, ~a_oe});
    chk("wr def", {4'hF, 16'h5AC3}, {wr, dc, mio, d_oe, dout});
    xfer_done_n = 1'h0;
    for (int i = 0; i < 20 && op_done !== 1'h1; i++) begin
      if (s_n === 1'h0) begin
        n++;
        chk("addr", 23'h000100 + n, addr);
      end
      chk("lock pin", 1, lk);
      chk("gnt mid", 0, gnt);
      tick(1);
    end
    chk("pieces", 2, n);
    chk("done", 1, op_done);
    xfer_done_n = 1'h1;
    op_write = 1'h0;
    op_pieces = 2'h1;
    wait_sig(gnt, 1'h1, "gnt after");
    wait_sig(gnt, 1'h0, "gnt end");
  endtask
  task automatic t_lock();
    seq_active = 1'h1;
    lock_seq = 1'h1;
    op_valid = 1'h1;
    wait_sig(op_ready, 1'h1, "ready");
    tick(1);
    op_valid = 1'h0;
    lock_seq = 1'h0;
    chk("lock read", 3'h0, {lk, d_oe, wr});
    xfer_done_n = 1'h0;
    wait_sig(op_done, 1'h1, "done");
    chk("rdata", 16'hA55A, rdata);
    xfer_done_n = 1'h1;
    pulse_start();
    tick(8);
    chk("gnt in seq", 0, gnt);
    seq_active = 1'h0;
    wait_sig(gnt, 1'h1, "gnt seq");
    wait_sig(gnt, 1'h0, "gnt end");
  endtask
  task automatic t_reset_hold();
    hold_len = 8'h28;
    pulse_start();
    wait_sig(gnt, 1'h1, "gnt");
    bus_reset = 1'h1;
    tick(1);
    chk("rst wins", {5'h1F, idle}, {oe_all, pins});
    bus_reset = 1'h0;
    wait_sig(gnt, 1'h1, "regnt");
    wait_sig(gnt, 1'h0, "gnt end");
  endtask
  task automatic t_nmi();
    hold_len = 8'h20;
    pulse_start();
    wait_sig(gnt, 1'h1, "gnt");
    nmi_pin = 1'h1;
    tick(8);
    nmi_served = 1'h1;
    tick(2);
    nmi_served = 1'h0;
    nmi_pin = 1'h0;
    chk("nmi hold", 1, nmi_pending);
    wait_sig(gnt, 1'h0, "gnt end");
    tick(2);
    chk("nmi kept", 1, nmi_pending);
    nmi_served = 1'h1;
    tick(1);
    nmi_served = 1'h0;
    tick(1);
    chk("nmi clr", 0, nmi_pending);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    tick(5);
    chk("rst idle", {5'h1F, idle}, {oe_all, pins});
    rstn = 1'h1;
    bus_reset = 1'h1;
    pulse_start();
    tick(6);
    chk("req in rst", idle, pins);
    bus_reset = 1'h0;
    wait_sig(gnt, 1'h1, "gnt");
    wait_sig(gnt, 1'h0, "gnt end");
    t_hold();
    t_split();
    t_lock();
    t_reset_hold();
    t_nmi();
    end_of_test();
  end
endmodule
